//--- design/power_budget_capability_regs.sv
// power budgeting extended capability registers behind an axi4-lite slave
`default_nettype none
module power_budget_capability_regs (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic upstream_port,
  input wire power_budget_pkg::autoload_t autoload,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  import power_budget_pkg::*;

  // word match on the upper address bits; byte lane bits are don't care
  function automatic logic addr_hit(input logic [11:0] a,
                                    input logic [11:0] off);
    addr_hit = (a[11:2] == off[11:2]);
  endfunction : addr_hit

  function automatic logic addr_mapped(input logic [11:0] a);
    addr_mapped = addr_hit(a, hdr_off) | addr_hit(a, sel_off) |
                  addr_hit(a, desc_off) | addr_hit(a, alloc_off);
  endfunction : addr_mapped

  logic upstream_ff;
  logic strap_meta_ff;
  logic strap_sync_ff;
  logic [7:0] sel_ff;
  logic [7:0] base_power_ff;
  logic sys_alloc_ff;
  logic aw_held_ff;
  logic [11:0] aw_addr_ff;
  logic w_held_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic wr_fire;
  logic rd_fire;
  cap_header_t header;
  descriptor_t desc;
  logic [31:0] nxt_rdata;
  logic [1:0] nxt_rresp;

  // the strap is a pin, so two flops come before anything reads it
  always_ff @(posedge aclk) begin
    strap_meta_ff <= upstream_port;
    strap_sync_ff <= strap_meta_ff;
  end

  // port role is a strap: caught while reset is held, steady afterwards;
  // reset must be held three edges for the synchronised value to land
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      upstream_ff <= strap_sync_ff;
    end
  end

  // write address and write data are taken independently, in any order
  assign awready = !aw_held_ff && !bvalid_ff;
  assign wready = !w_held_ff && !bvalid_ff;
  assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= 12'h000;
    end else if (awvalid && awready) begin
      aw_held_ff <= 1'b1;
      aw_addr_ff <= awaddr;
    end else if (wr_fire) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_ff <= 1'b0;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
    end else if (wvalid && wready) begin
      w_held_ff <= 1'b1;
      w_data_ff <= wdata;
      w_strb_ff <= wstrb;
    end else if (wr_fire) begin
      w_held_ff <= 1'b0;
    end
  end

  // response waits for both halves; unmapped words answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= resp_okay;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= addr_mapped(aw_addr_ff) ? resp_okay : resp_slverr;
    end else if (bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;

  // only the index byte is stored, so upper bits cannot be kept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_ff <= sel_rst;
    end else if (wr_fire && addr_hit(aw_addr_ff, sel_off) &&
                 w_strb_ff[0]) begin
      sel_ff <= w_data_ff[7:0];
    end
  end

  // eeprom loader may replace the defaults at any time after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      base_power_ff <= base_rst;
      sys_alloc_ff <= alloc_rst;
    end else if (autoload.valid) begin
      base_power_ff <= autoload.base_power;
      sys_alloc_ff <= autoload.sys_alloc;
    end
  end

  always_comb begin
    header.cap_id = cap_id_val;
    header.version = cap_ver_val;
    header.next_ptr = upstream_ff ? next_up_val : next_dn_val;
  end

  // both supported entries share one base power; only the type differs
  always_comb begin
    desc = '0;
    if (sel_ff == idx_max || sel_ff == idx_sus) begin
      desc.base_power = base_power_ff;
      desc.scale = scale_rst;
      desc.sub_state = sub_rst;
      desc.pm_state = pm_rst;
      desc.rail = rail_rst;
      desc.cond_type = (sel_ff == idx_sus) ?
                       type_sus : type_max;
    end
  end

  // read data is registered; one read outstanding at a time
  assign arready = !rvalid_ff;
  assign rd_fire = arvalid && arready;

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_rresp = resp_okay;
    if (addr_hit(araddr, hdr_off)) begin
      nxt_rdata = header;
    end else if (addr_hit(araddr, sel_off)) begin
      nxt_rdata = {24'h000000, sel_ff};
    end else if (addr_hit(araddr, desc_off)) begin
      nxt_rdata = desc;
    end else if (addr_hit(araddr, alloc_off)) begin
      nxt_rdata = {31'h00000000, sys_alloc_ff};
    end else begin
      nxt_rresp = resp_slverr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= resp_okay;
    end else if (rd_fire) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end else if (rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence hdr_read_s;
    rd_fire && addr_hit(araddr, hdr_off);
  endsequence

  sequence desc_read_s;
    rd_fire && addr_hit(araddr, desc_off);
  endsequence

  sequence sel_wr_s;
    wr_fire && addr_hit(aw_addr_ff, sel_off) && w_strb_ff[0];
  endsequence

  a_hdr_id_fixed: assert property (
    hdr_read_s |=> rvalid && rdata[15:0] == 16'h0004)
    else $error("header identifier wrong");

  a_hdr_version: assert property (
    hdr_read_s |=> rdata[19:16] == 4'h1 && rresp == resp_okay)
    else $error("header version wrong");

  a_next_up: assert property (
    hdr_read_s ##0 upstream_ff |=> rdata[31:20] == 12'h230)
    else $error("upstream next pointer wrong");

  a_next_dn: assert property (
    hdr_read_s ##0 !upstream_ff |=> rdata[31:20] == 12'h220)
    else $error("downstream next pointer wrong");

  a_sel_write: assert property (
    sel_wr_s |=> sel_ff == $past(w_data_ff[7:0]) && bvalid)
    else $error("index write not stored");

  a_sel_resp: assert property (
    sel_wr_s |=> bresp == resp_okay)
    else $error("index write refused");

  a_sel_readback: assert property (
    rd_fire && addr_hit(araddr, sel_off)
    |=> rdata[31:8] == 24'h000000 && rdata[7:0] == $past(sel_ff))
    else $error("index readback wrong");

  a_desc_max: assert property (
    desc_read_s ##0 sel_ff == 8'h00
    |=> rdata[17:15] == 3'h7 && rdata[7:0] == $past(base_power_ff))
    else $error("maximum entry wrong");

  a_desc_sustain: assert property (
    desc_read_s ##0 sel_ff == 8'h01
    |=> rdata[17:15] == 3'h3 && rdata[20:18] == 3'h2)
    else $error("sustained entry wrong");

  a_desc_unsupported: assert property (
    desc_read_s ##0 sel_ff > 8'h01 |=> rdata == 32'h0000_0000)
    else $error("unsupported entry not zero");

  a_desc_fixed: assert property (
    desc_read_s ##0 sel_ff <= 8'h01
    |=> rdata[14:8] == 7'h00 && rdata[31:21] == 11'h000)
    else $error("descriptor fixed fields wrong");

  a_base_reset: assert property (
    $rose(aresetn) |-> base_power_ff == 8'h04 && sys_alloc_ff == 1'b0
    && sel_ff == 8'h00)
    else $error("reset defaults wrong");

  a_autoload_take: assert property (
    autoload.valid |=> base_power_ff == $past(autoload.base_power)
    && sys_alloc_ff == $past(autoload.sys_alloc))
    else $error("autoload not taken");

  a_alloc_read: assert property (
    rd_fire && addr_hit(araddr, alloc_off)
    |=> rdata == {31'h00000000, $past(sys_alloc_ff)})
    else $error("allocation readback wrong");

  a_bresp_hold: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");

  a_rresp_hold: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read response dropped");

  a_unmapped_err: assert property (
    rd_fire && !addr_mapped(araddr) |=> rresp == resp_slverr)
    else $error("unmapped read not refused");

  a_wr_resp_time: assert property (
    wr_fire |=> bvalid [*1] ##0 !aw_held_ff && !w_held_ff)
    else $error("write response late");

  a_sel_strobe_off: assert property (
    wr_fire && addr_hit(aw_addr_ff, sel_off) && !w_strb_ff[0]
    |=> $stable(sel_ff))
    else $error("masked index write stored");

  a_ro_unchanged: assert property (
    wr_fire && !autoload.valid
    |=> $stable(base_power_ff) && $stable(sys_alloc_ff))
    else $error("read-only field written");

  a_strap_steady: assert property (
    aresetn |=> $stable(upstream_ff))
    else $error("port role changed after reset");

  a_desc_rail: assert property (
    desc_read_s ##0 sel_ff == 8'h00 |=> rdata[20:18] == 3'h2)
    else $error("supply rail wrong");

  a_wr_refused: assert property (
    bvalid |-> !awready && !wready)
    else $error("write taken while response pending");

  a_rd_refused: assert property (
    rvalid |-> !arready)
    else $error("read taken while data pending");

  a_rd_resp_time: assert property (
    rd_fire |=> rvalid)
    else $error("read response late");

endmodule : power_budget_capability_regs
`default_nettype wire

//--- design/power_budget_pkg.sv
// constants and types shared by the power budget capability registers
`default_nettype none
package power_budget_pkg;
  // register byte offsets in configuration space
  localparam logic [11:0] hdr_off = 12'h20c;
  localparam logic [11:0] sel_off = 12'h210;
  localparam logic [11:0] desc_off = 12'h214;
  localparam logic [11:0] alloc_off = 12'h218;

  // capability header contents
  localparam logic [15:0] cap_id_val = 16'h0004;
  localparam logic [3:0] cap_ver_val = 4'h1;
  localparam logic [11:0] next_up_val = 12'h230;
  localparam logic [11:0] next_dn_val = 12'h220;

  // selection index and its decoded entries
  localparam logic [7:0] sel_rst = 8'h00;
  localparam logic [7:0] idx_max = 8'h00;
  localparam logic [7:0] idx_sus = 8'h01;

  // descriptor reset values
  localparam logic [7:0] base_rst = 8'h04;
  localparam logic [1:0] scale_rst = 2'h0;
  localparam logic [2:0] sub_rst = 3'h0;
  localparam logic [1:0] pm_rst = 2'h0;
  localparam logic [2:0] type_max = 3'h7;
  localparam logic [2:0] type_sus = 3'h3;
  localparam logic [2:0] rail_rst = 3'h2;
  localparam logic alloc_rst = 1'b0;

  // bus responses
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  // descriptor layout, bit 0 at the bottom of base_power
  typedef struct packed {
    logic [10:0] rsvd;
    logic [2:0] rail;
    logic [2:0] cond_type;
    logic [1:0] pm_state;
    logic [2:0] sub_state;
    logic [1:0] scale;
    logic [7:0] base_power;
  } descriptor_t;

  typedef struct packed {
    logic [11:0] next_ptr;
    logic [3:0] version;
    logic [15:0] cap_id;
  } cap_header_t;

  // one-cycle load from the serial eeprom loader
  typedef struct packed {
    logic valid;
    logic [7:0] base_power;
    logic sys_alloc;
  } autoload_t;
endpackage : power_budget_pkg
`default_nettype wire

//--- dv/power_budget_capability_regs_tb_top.sv
// self-checking bench for the power budget capability registers
`default_nettype none
module power_budget_capability_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import power_budget_pkg::*;

  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic upstream_port = 1'b1;
  autoload_t autoload = '0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int failures = 0;
  int samples_checked = 0;
  // each note: {compare data, response, data}
  logic [34:0] notes[$];
  logic [31:0] seed = 32'h0000_2105;

  power_budget_capability_regs dut (.aclk(aclk), .aresetn(aresetn),
    .upstream_port(upstream_port), .autoload(autoload),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));

  initial begin
    forever #4 aclk = ~aclk;
  end

  task automatic test_done;
    if (failures == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  initial begin
    #(8 * 20000);
    failures++;
    test_done;
  end

  // mid-cycle sampling: handshake values are settled well clear of edges
  always @(negedge aclk) begin
    logic [34:0] n;
    if ((rvalid === 1'b1 && rready) || (bvalid === 1'b1 && bready)) begin
      samples_checked++;
      if (notes.size() == 0) begin
        failures++;
        $display("wrong value response expected none seen one");
      end else begin
        n = notes.pop_front();
        if (rvalid === 1'b1 && rready) begin
          if (rresp !== n[33:32] || (n[34] && rdata !== n[31:0])) begin
            failures++;
            $display("wrong value read expected %h seen %h", n[33:0],
              {rresp, rdata});
          end
        end else if (bresp !== n[33:32]) begin
          failures++;
          $display("wrong value bresp expected %h seen %h", n[33:32], bresp);
        end
      end
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  function automatic logic [31:0] exp_desc(input logic [7:0] i,
      input logic [7:0] b);
    descriptor_t e;
    e = '0;
    if (i <= 8'h01) begin
      e.base_power = b;
      e.scale = 2'b00;
      e.sub_state = 3'b000;
      e.pm_state = 2'b00;
      e.rail = 3'b010;
      e.cond_type = (i == 8'h00) ? 3'b111 : type_sus;
    end
    return e;
  endfunction : exp_desc

  task automatic do_reset(input logic up);
    aresetn <= 1'b0;
    upstream_port <= up;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset

  // one read (rd=1, d expected) or one write (rd=0, d written)
  task automatic xfer(input logic rd, input logic [11:0] a,
      input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
    logic ta, tw, tb;
    int k;
    notes.push_back({rd && r == resp_okay, r, d});
    @(posedge aclk);
    if (rd) begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end else begin
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end
    tb = 1'b0;
    for (k = 0; k < 50 && !tb; k++) begin
      @(negedge aclk);
      ta = rd ? (arvalid && arready) : (awvalid && awready);
      tw = wvalid && wready;
      tb = rd ? (rvalid === 1'b1 && rready) : (bvalid === 1'b1 && bready);
      @(posedge aclk);
      if (ta) begin
        arvalid <= 1'b0;
        awvalid <= 1'b0;
      end
      if (tw) wvalid <= 1'b0;
      if (tb) begin
        rready <= 1'b0;
        bready <= 1'b0;
      end
    end
    if (!tb) begin
      failures++;
      $display("wrong value handshake expected answer seen none");
    end
  endtask : xfer

  initial begin
    logic [7:0] idx;
    logic [7:0] b;
    int j;
    do_reset(1'b1);
    xfer(1, hdr_off, 32'h2301_0004, 4'h0, resp_okay);
    xfer(1, sel_off, 32'h0, 4'h0, resp_okay);
    xfer(1, desc_off, exp_desc(8'h00, 8'h04), 4'h0, resp_okay);
    xfer(1, alloc_off, 32'h0, 4'h0, resp_okay);
    // read-only places must keep their contents
    xfer(0, hdr_off, 32'hffff_ffff, 4'hf, resp_okay);
    xfer(0, desc_off, 32'hffff_ffff, 4'hf, resp_okay);
    xfer(0, alloc_off, 32'hffff_ffff, 4'hf, resp_okay);
    xfer(1, hdr_off, 32'h2301_0004, 4'h0, resp_okay);
    xfer(1, desc_off, exp_desc(8'h00, 8'h04), 4'h0, resp_okay);
    xfer(1, alloc_off, 32'h0, 4'h0, resp_okay);
    xfer(0, sel_off, 32'hffff_ff01, 4'hf, resp_okay);
    xfer(1, sel_off, 32'h1, 4'h0, resp_okay);
    xfer(1, desc_off, exp_desc(8'h01, 8'h04), 4'h0, resp_okay);
    xfer(0, sel_off, 32'h0, 4'he, resp_okay);
    xfer(1, sel_off, 32'h1, 4'h0, resp_okay);
    xfer(0, 12'h21c, 32'h0, 4'hf, resp_slverr);
    xfer(1, 12'h21c, 32'h0, 4'h0, resp_slverr);
    for (j = 0; j < 12; j++) begin
      seed = xs(seed);
      idx = (j < 3) ? j[7:0] : seed[7:0];
      xfer(0, sel_off, {seed[31:8], idx}, 4'hf, resp_okay);
      xfer(1, sel_off, {24'h0, idx}, 4'h0, resp_okay);
      xfer(1, desc_off, exp_desc(idx, 8'h04), 4'h0, resp_okay);
    end
    seed = xs(seed);
    b = seed[7:0];
    @(posedge aclk);
    autoload <= '{1'b1, b, 1'b1};
    @(posedge aclk);
    autoload <= '0;
    xfer(0, sel_off, 32'h0, 4'hf, resp_okay);
    xfer(1, desc_off, exp_desc(8'h00, b), 4'h0, resp_okay);
    xfer(1, alloc_off, 32'h1, 4'h0, resp_okay);
    xfer(0, sel_off, 32'h1, 4'hf, resp_okay);
    do_reset(1'b0);
    xfer(1, hdr_off, 32'h2201_0004, 4'h0, resp_okay);
    xfer(1, sel_off, 32'h0, 4'h0, resp_okay);
    xfer(1, desc_off, exp_desc(8'h00, 8'h04), 4'h0, resp_okay);
    xfer(1, alloc_off, 32'h0, 4'h0, resp_okay);
    repeat (4) @(posedge aclk);
    test_done;
  end
endmodule : power_budget_capability_regs_tb_top
`default_nettype wire
